// File: core/lsesq_pkg.sv
package lsesq_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned ARM_DELAY_S   = 5;
    localparam longint      ARM_CYCLES    = longint'(ARM_DELAY_S) * longint'(CLK_HZ);

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0c;

    // CTRL fields
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // Interrupt bits
    localparam int IRQ_W              = 4;
    localparam int IRQ_OVERTEMP       = 0;
    localparam int IRQ_ILK_OPEN       = 1;
    localparam int IRQ_ILK_CLOSE      = 2;
    localparam int IRQ_LASE_ON        = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    // STATUS field positions
    localparam int ST_ILK       = 0;
    localparam int ST_READY     = 1;
    localparam int ST_LASE      = 2;
    localparam int ST_SHUTTER   = 3;
    localparam int ST_RFPOWER   = 4;
    localparam int ST_OVERTEMP  = 5;
    localparam int ST_RSTREQ    = 6;
    localparam int ST_W         = 7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic interlock;
        logic shutterReq;
        logic resetReq;
        logic overTemp;
        logic pwmCmd;
        logic tickle;
    } lsesq_pins_t;

    localparam int PIN_W = $bits(lsesq_pins_t);

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } lsesq_apb_req_t;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b001,
        SEQ_COUNT = 3'b010,
        SEQ_ARMED = 3'b100
    } lsesq_seq_t;

endpackage

// File: core/lsesq_sequencer.sv
`timescale 1ns/10ps
// Function
// RULE1: Power-up: ready at once, RF power after delay
// RULE2: PWM passes only with shutter, interlock, ready
// RULE3: Over-temperature latches until power cycle
// RULE4: Interlock fault unlatched; re-arms after delay
// RULE5: Reset/start request inhibits RF and lasing
// RULE6: Request release powers RF, starts countdown
// RULE7: Ready output tracks ready state
// RULE8: Lasing waits delay after ready output closes
// RULE9: Lasing only while shutter open
// RULE10: Shutter opens on request only when ready
// RULE11: Shutter closed passes tickle pulses only
// RULE12: Shutter output equals request and ready
// RULE13: RF power needs interlock closed and ready
// RULE14: Interlock closes: lamp, ready, power, tickle later
// RULE15: Interlock opens: cut power, red, not ready
// RULE16: Interlock-open output mirrors open circuit
// RULE17: Not ready removes all RF power
// RULE18: Sync inputs; dropped condition restarts countdown
module lsesq_sequencer
#(
    parameter longint ArmCycles = lsesq_pkg::ARM_CYCLES
)
(
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire lsesq_pkg::lsesq_pins_t  pinsIn,
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic                         rfPowerEn,
    output logic                         rfDrive,
    output logic                         readyLamp,
    output logic                         readyOut,
    output logic                         shutterOpen,
    output logic                         shutter_lamp,
    output logic                         shutterOut,
    output logic                         interlockLampGreen,
    output logic                         interlockOpenOut,
    output logic                         irq
);
    import lsesq_pkg::*;

    localparam int CW = $clog2(ArmCycles + 1);

    initial
    begin
        if (ArmCycles < 1 || ArmCycles > 64'h0000_0000_ffff_ffff)
            $error("ArmCycles out of range");
    end

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    lsesq_pins_t sync1_q;
    lsesq_pins_t sync2_q;
    lsesq_pins_t sync3_q;
    lsesq_pins_t pins_q;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sync1_q <= '0;
        else
            sync1_q <= pinsIn;                                   // [RULE18]
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sync2_q <= '0;
        else
            sync2_q <= sync1_q;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sync3_q <= '0;
        else
            sync3_q <= sync2_q;
    end

    // A level only changes once the second and third stages agree
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            pins_q <= '0;
        else
            pins_q <= lsesq_pins_t'((sync2_q & sync3_q) | (pins_q & (sync2_q | sync3_q)));
    end

    // ------------------------------------------------------------------
    // Registers and enable state
    // ------------------------------------------------------------------
    logic [31:0]      ctrl_q;
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic             overTemp_q;
    logic             bootDone_q;
    logic             ilkPrev_q;
    logic             lasePrev_q;
    logic [CW-1:0]    count_q;
    lsesq_seq_t       seq_q;
    lsesq_seq_t       seq_d;

    wire ilkClosed  = pins_q.interlock;
    wire inhibit    = pins_q.resetReq | ctrl_q[CTRL_INHIBIT_BIT];
    wire readyCond  = ilkClosed & ~inhibit & ~overTemp_q;           // [RULE3] [RULE5] [RULE15]
    wire countDone  = (count_q == CW'(ArmCycles - 1));
    wire laseEn     = (seq_q == SEQ_ARMED);                         // [RULE8]
    wire rfPowerD   = readyCond & (bootDone_q | laseEn);            // [RULE1] [RULE13] [RULE17]
    wire shutterD   = pins_q.shutterReq & readyCond;                // [RULE10] [RULE12]
    wire driveLase  = rfPowerD & laseEn & shutterD & pins_q.pwmCmd; // [RULE2] [RULE9]
    wire driveTick  = rfPowerD & laseEn & ~shutterD & pins_q.tickle; // [RULE11] [RULE14]

    always_comb
    begin
        seq_d = seq_q;
        unique case (seq_q)
            SEQ_IDLE:  if (readyCond) seq_d = SEQ_COUNT;             // [RULE4] [RULE6]
            SEQ_COUNT: if (!readyCond) seq_d = SEQ_IDLE;             // [RULE18]
                       else if (countDone) seq_d = SEQ_ARMED;
            SEQ_ARMED: if (!readyCond) seq_d = SEQ_IDLE;             // [RULE15]
            default:   seq_d = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            seq_q <= SEQ_IDLE;
        else
            seq_q <= seq_d;
    end

    // Countdown restarts from zero whenever the state leaves SEQ_COUNT
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            count_q <= '0;
        else
            count_q <= (seq_q == SEQ_COUNT && seq_d == SEQ_COUNT) ? count_q + 1'b1 : '0;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            overTemp_q <= 1'b0;
        else
            overTemp_q <= overTemp_q | pins_q.overTemp;              // [RULE3]
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            bootDone_q <= 1'b0;
        else
            bootDone_q <= bootDone_q | laseEn;                       // [RULE1]
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            ilkPrev_q <= 1'b0;
        else
            ilkPrev_q <= ilkClosed;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            lasePrev_q <= 1'b0;
        else
            lasePrev_q <= laseEn;
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rfPowerEn <= 1'b0;
        end
        else
        begin
            rfPowerEn <= rfPowerD;                                   // [RULE13] [RULE17]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rfDrive <= 1'b0;
        end
        else
        begin
            rfDrive <= driveLase | driveTick;                        // [RULE2] [RULE11]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            readyLamp <= 1'b0;
        end
        else
        begin
            readyLamp <= readyCond;                                  // [RULE1] [RULE4]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            readyOut <= 1'b0;
        end
        else
        begin
            readyOut <= readyCond;                                   // [RULE7]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            shutterOpen <= 1'b0;
        end
        else
        begin
            shutterOpen <= shutterD;                                 // [RULE9]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            shutter_lamp <= 1'b0;
        end
        else
        begin
            shutter_lamp <= shutterD;                                // [RULE10]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            shutterOut <= 1'b0;
        end
        else
        begin
            shutterOut <= shutterD;                                  // [RULE12]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            interlockLampGreen <= 1'b0;
        end
        else
        begin
            interlockLampGreen <= ilkClosed;                         // [RULE14] [RULE15]
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            interlockOpenOut <= 1'b0;
        end
        else
        begin
            interlockOpenOut <= ~ilkClosed;                          // [RULE16]
        end
    end

    // ------------------------------------------------------------------
    // APB slave and interrupts
    // ------------------------------------------------------------------
    wire accessCyc = psel & penable & ~pready;
    wire doneCyc   = psel & penable & pready;
    wire hitCtrl   = (paddr == ADDR_CTRL);
    wire hitStat   = (paddr == ADDR_STATUS);
    wire hitIrqS   = (paddr == ADDR_IRQ_STAT);
    wire hitIrqM   = (paddr == ADDR_IRQ_MASK);
    wire mapped    = hitCtrl | hitStat | hitIrqS | hitIrqM;
    wire wrEn      = doneCyc & pwrite & ~pslverr;

    wire [ST_W-1:0] status = {inhibit, overTemp_q, rfPowerD, shutterD, laseEn,
                              readyCond, ilkClosed};

    wire [IRQ_W-1:0] irqEvents = {laseEn & ~lasePrev_q,
                                  ilkClosed & ~ilkPrev_q,
                                  ~ilkClosed & ilkPrev_q,
                                  pins_q.overTemp & ~overTemp_q};

    wire [IRQ_W-1:0] irqClr  = (wrEn && hitIrqS) ? pwdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irqNext = (irqStat_q & ~irqClr) | irqEvents;

    wire [31:0] rdMux = hitCtrl ? ctrl_q :
                        hitStat ? {{(32-ST_W){1'b0}}, status} :
                        hitIrqS ? {{(32-IRQ_W){1'b0}}, irqStat_q} :
                        hitIrqM ? {{(32-IRQ_W){1'b0}}, irqMask_q} : 32'h0000_0000;

    // One wait state: pready answers the first access-phase edge
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= accessCyc;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= accessCyc & ~mapped;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata <= 32'h0000_0000;
        end
        else
        begin
            prdata <= (accessCyc && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            ctrl_q <= CTRL_RESET;
        else if (wrEn && hitCtrl)
            ctrl_q <= {31'h0000_0000, pwdata[CTRL_INHIBIT_BIT]};
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            irqMask_q <= IRQ_RESET;
        else if (wrEn && hitIrqM)
            irqMask_q <= pwdata[IRQ_W-1:0];
    end

    // Event set wins over a write-one clear in the same cycle
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            irqStat_q <= IRQ_RESET;
        else
            irqStat_q <= irqNext;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irqNext & irqMask_q);
        end
    end

endmodule // lsesq_sequencer

// File: verif/lsesq_chk.sv
`timescale 1ns/10ps
module lsesq_chk
#(
    parameter longint ArmCycles = 20
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic readyLamp,
    input wire logic readyOut,
    input wire logic shutterOpen,
    input wire logic shutter_lamp,
    input wire logic shutterOut,
    input wire logic rfPowerEn,
    input wire logic rfDrive,
    input wire logic interlockLampGreen,
    input wire logic interlockOpenOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_ready_rise;
        $rose(readyOut);
    endsequence
    sequence s_no_drive;
        !rfDrive [*8];
    endsequence

    a_arm_holdoff: assert property (s_ready_rise |-> s_no_drive)
        else $error("drive active right after ready");
    a_ready_pair: assert property (readyLamp == readyOut)
        else $error("ready lamp and output differ");
    a_shutter_pair: assert property (shutterOut == shutter_lamp && shutterOpen == shutterOut)
        else $error("shutter signals differ");
    a_shutter_ready: assert property (shutterOut |-> readyOut)
        else $error("shutter open without ready");
    a_ready_green: assert property (readyLamp |-> interlockLampGreen)
        else $error("ready with interlock red");
    a_green_open: assert property (interlockLampGreen |-> !interlockOpenOut)
        else $error("green lamp with open output");
    a_drive_ready: assert property (rfDrive |-> readyOut && rfPowerEn)
        else $error("drive without ready and power");
    a_power_off: assert property (!readyOut [*2] |-> !rfPowerEn)
        else $error("rf power while not ready");
    a_power_green: assert property (!interlockLampGreen [*2] |-> !rfPowerEn)
        else $error("rf power with interlock red");
endmodule // lsesq_chk

bind lsesq_sequencer lsesq_chk #(.ArmCycles(ArmCycles)) chk_u (.clock, .nrst, .readyLamp,
    .readyOut, .shutterOpen, .shutter_lamp, .shutterOut, .rfPowerEn, .rfDrive,
    .interlockLampGreen, .interlockOpenOut);

// File: verif/lsesq_ctl_model.sv
`timescale 1ns/10ps
module lsesq_ctl_model
(
    input  wire logic             clock,
    input  wire lsesq_pkg::lsesq_pins_t want,
    output lsesq_pkg::lsesq_pins_t      pins
);
    import lsesq_pkg::*;
    initial pins = '0;
    // Control system raises and drops its request levels after an edge
    always @(posedge clock) pins <= want;
endmodule // lsesq_ctl_model

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
    import lsesq_pkg::*;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    lsesq_pins_t want = '0;
    lsesq_pins_t pinsIn;
    logic [7:0]  paddr = '0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, rfPowerEn, rfDrive, readyLamp, readyOut, irq;
    logic        shutterOpen, shutter_lamp, shutterOut, interlockLampGreen, interlockOpenOut;
    logic [32:0] expQ[$];
    int          n_fail = 0;
    int          samples_checked = 0;
    logic        r;

    always #12.5 clock = ~clock;

    lsesq_ctl_model ctl_u (.clock, .want, .pins(pinsIn));
    lsesq_sequencer #(.ArmCycles(20)) dut_u (.clock, .nrst, .pinsIn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .rfPowerEn, .rfDrive,
        .readyLamp, .readyOut, .shutterOpen, .shutter_lamp, .shutterOut,
        .interlockLampGreen, .interlockOpenOut, .irq);

    task tally_and_finish;
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk_rd(input logic [32:0] g, input logic [32:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %0t read %h exp %h", $time, g, e);
        end
    endtask
    task chk_pin(input logic [5:0] e);
        samples_checked++;
        if ({readyOut, shutterOut, rfPowerEn, interlockOpenOut, rfDrive, irq} !== e)
        begin
            n_fail++;
            $display("mismatch %0t outputs exp %b", $time, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Read monitor
    // ------------------------------------------------------------------
    always @(posedge clock)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk_rd({pslverr, prdata}, expQ.pop_front());

    initial
    begin
        cyc(5000);
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(86));
        cyc(2);
        nrst <= 1'b1;
        cyc(8);
        chk_pin(6'b000100);
        want.interlock <= 1'b1;
        want.tickle <= 1'b1;
        cyc(8);
        chk_pin(6'b100000);
        cyc(30);
        chk_pin(6'b101010);
        rd(ADDR_STATUS, 33'h17);
        want.shutterReq <= 1'b1;
        repeat (4)
        begin
            r = 1'($urandom);
            want.pwmCmd <= r;
            cyc(8);
            chk_pin({4'b1110, r, 1'b0});
        end
        rd(ADDR_STATUS, 33'h1f);
        want.pwmCmd <= 1'b1;
        want.resetReq <= 1'b1;
        cyc(8);
        chk_pin(6'b000000);
        want.resetReq <= 1'b0;
        cyc(8);
        chk_pin(6'b111000);
        want.resetReq <= 1'b1;
        cyc(4);
        want.resetReq <= 1'b0;
        cyc(14);
        chk_pin(6'b111000);
        cyc(20);
        chk_pin(6'b111010);
        apb(1'b1, ADDR_IRQ_MASK, 32'h2);
        want.interlock <= 1'b0;
        cyc(8);
        chk_pin(6'b000101);
        apb(1'b1, ADDR_IRQ_STAT, 32'h2);
        cyc(2);
        chk_pin(6'b000100);
        rd(ADDR_IRQ_MASK, 33'h2);
        rd(8'h10, {1'b1, 32'h0});
        want.interlock <= 1'b1;
        cyc(8);
        chk_pin(6'b111000);
        cyc(30);
        chk_pin(6'b111010);
        want.overTemp <= 1'b1;
        cyc(6);
        want.overTemp <= 1'b0;
        cyc(10);
        chk_pin(6'b000000);
        rd(ADDR_STATUS, 33'h21);
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(8);
        chk_pin(6'b110000);
        cyc(30);
        chk_pin(6'b111010);
        tally_and_finish();
    end
endmodule // tb
